// file: periodic_timer_core_tb.sv
// Purpose: self-checking bench for the periodic timer core
// Assumes: zero-wait apb slave; tick inputs pulse every other cycle
// Notes: the overflow run walks the whole 16-bit count
`timescale 1ns/1ps
module periodic_timer_core_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic hi_tick = 1'b0;
  logic sub_tick = 1'b0;
  logic run = 1'b0;
  logic [ptc_pkg::ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, ext_pin, pin, pin_n, fa, fp;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #5 pclk = ~pclk;
  ptc_core ptc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .high_clock_tick(hi_tick), .sub_clock_tick(sub_tick), .external_count_clock_pin(ext_pin),
    .timer_output_pin(pin), .timer_output_pin_inverse(pin_n), .compare_a_flag(fa), .compare_p_flag(fp));
  ptc_ext_model ptc_ext_model_inst (.pclk(pclk), .run(run), .external_count_clock_pin(ext_pin));
  task automatic give_verdict;
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // timeout sized for the 65536-cycle overflow run plus margin
  always @(posedge pclk) begin
    hi_tick <= ~hi_tick;
    sub_tick <= ~sub_tick;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      give_verdict();
    end
  end
  always @(negedge pclk) begin
    if (presetn) chk("inverse pin", {31'h0, !pin}, {31'h0, pin_n});
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(n, e, rd);
  endtask
  task automatic t_regs;
    chk("reset outputs", 32'h8, {28'h0, pin_n, pin, fp, fa});
    rchk("ctl1", ptc_pkg::OFF_CTL1, 32'h0);
    rchk("count", ptc_pkg::OFF_CNT_HI, 32'h0);
    wr(ptc_pkg::OFF_CTL0, 8'hf7);
    rchk("ctl0", ptc_pkg::OFF_CTL0, 32'hf0);
    wr(ptc_pkg::OFF_CNT_LO, 8'h5a);
    rchk("count lo", ptc_pkg::OFF_CNT_LO, 32'h0);
    wr(ptc_pkg::OFF_PER_HI, 8'ha5);
    rchk("period hi", ptc_pkg::OFF_PER_HI, 32'ha5);
    apb(1'b0, 8'h24, 8'h00);
    chk("slverr", 32'h1, {31'h0, err});
  endtask
  task automatic t_clk;
    int dv[8] = '{4, 1, 32, 128, 2, 2, 8, 8};
    int e;
    logic [31:0] held;
    wr(ptc_pkg::OFF_CTL1, 8'hc0);
    for (int i = 0; i < 8; i++) begin
      wr(ptc_pkg::OFF_CTL0, 8'h00);
      wr(ptc_pkg::OFF_CTL0, 8'(i * 16 + 8));
      run <= (i >= 6);
      repeat (dv[i] * 10) @(posedge pclk);
      run <= 1'b0;
      repeat (8) @(posedge pclk);
      wr(ptc_pkg::OFF_CTL0, 8'(i * 16));
      e = (i >= 6) ? 10 : (dv[i] * 10 + 11) / dv[i];
      apb(1'b0, ptc_pkg::OFF_CNT_LO, 8'h00);
      chk("count rate", 32'h1, {31'h0, rd + 1 >= e && rd <= e + 1});
      held = rd;
      repeat (8) @(posedge pclk);
      rchk("count off", ptc_pkg::OFF_CNT_LO, held);
    end
    wr(ptc_pkg::OFF_CTL0, 8'h18);
    wr(ptc_pkg::OFF_CTL0, 8'h98);
    apb(1'b0, ptc_pkg::OFF_CNT_LO, 8'h00);
    held = rd;
    repeat (6) @(posedge pclk);
    rchk("paused", ptc_pkg::OFF_CNT_LO, held);
    wr(ptc_pkg::OFF_CTL0, 8'h18);
    apb(1'b0, ptc_pkg::OFF_CNT_LO, 8'h00);
    chk("resumed", 32'h1, {31'h0, rd > held});
  endtask
  task automatic t_cmp;
    logic lv, iv, fin;
    wr(ptc_pkg::OFF_PER_HI, 8'h10);
    wr(ptc_pkg::OFF_CMPA_LO, 8'h03);
    rchk("cmp a lo", ptc_pkg::OFF_CMPA_LO, 32'h3);
    for (int k = 0; k < 16; k++) begin
      lv = k[1];
      iv = k[0];
      fin = (k[3:2] == 2'h0) ? lv : (k[3:2] == 2'h3) ? !lv : k[3];
      wr(ptc_pkg::OFF_CTL0, 8'h00);
      wr(ptc_pkg::OFF_FLAGS, 8'h03);
      wr(ptc_pkg::OFF_CTL1, 8'(k * 4));
      wr(ptc_pkg::OFF_CTL0, 8'h18);
      repeat (2) @(posedge pclk);
      #1 chk("initial pin", {31'h0, lv ^ iv}, {31'h0, pin});
      repeat (20) @(posedge pclk);
      #1 chk("match pin", {31'h0, fin ^ iv}, {31'h0, pin});
      chk("flags", 32'h1, {30'h0, fp, fa});
    end
  endtask
  task automatic t_clr;
    wr(ptc_pkg::OFF_PER_HI, 8'h00);
    wr(ptc_pkg::OFF_PER_LO, 8'h02);
    wr(ptc_pkg::OFF_CMPA_LO, 8'h05);
    for (int c = 0; c < 2; c++) begin
      wr(ptc_pkg::OFF_CTL0, 8'h00);
      wr(ptc_pkg::OFF_FLAGS, 8'h03);
      wr(ptc_pkg::OFF_CTL1, 8'(c));
      wr(ptc_pkg::OFF_CTL0, 8'h18);
      repeat (30) @(posedge pclk);
      chk("clear flags", {30'h0, c == 0, c == 1}, {30'h0, fp, fa});
      rchk("flag reg", ptc_pkg::OFF_FLAGS, {30'h0, c == 0, c == 1});
      apb(1'b0, ptc_pkg::OFF_CNT_LO, 8'h00);
      chk("count bound", 32'h1, {31'h0, rd <= (c ? 5 : 2)});
    end
  endtask
  task automatic t_pwm;
    logic [7:0] cf[8] = '{8'h88, 8'h8c, 8'h98, 8'h9c, 8'ha8, 8'hac, 8'hcc, 8'h4c};
    logic ex[8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    for (int j = 0; j < 8; j++) begin
      wr(ptc_pkg::OFF_CTL0, 8'h00);
      wr(ptc_pkg::OFF_CTL1, cf[j]);
      wr(ptc_pkg::OFF_CTL0, 8'h18);
      repeat (4) @(posedge pclk);
      chk("pwm pin", {31'h0, ex[j]}, {31'h0, pin});
    end
    wr(ptc_pkg::OFF_CTL0, 8'h00);
    wr(ptc_pkg::OFF_FLAGS, 8'h03);
    wr(ptc_pkg::OFF_CTL1, 8'hb8);
    wr(ptc_pkg::OFF_CTL0, 8'h18);
    repeat (2) @(posedge pclk);
    #1 chk("pulse lead", 32'h1, {31'h0, pin});
    repeat (12) @(posedge pclk);
    #1 chk("pulse trail", 32'h1, {29'h0, pin, fp, fa});
    rchk("pulse off", ptc_pkg::OFF_CTL0, 32'h10);
  endtask
  task automatic t_ovf;
    wr(ptc_pkg::OFF_CTL0, 8'h00);
    wr(ptc_pkg::OFF_FLAGS, 8'h03);
    wr(ptc_pkg::OFF_CTL1, 8'h00);
    wr(ptc_pkg::OFF_CMPA_LO, 8'h00);
    wr(ptc_pkg::OFF_PER_LO, 8'h00);
    wr(ptc_pkg::OFF_CTL0, 8'h18);
    repeat (65540) @(posedge pclk);
    chk("overflow flags", 32'h2, {30'h0, fp, fa});
    rchk("wrapped", ptc_pkg::OFF_CNT_HI, 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk("reset ctl0", ptc_pkg::OFF_CTL0, 32'h0);
    rchk("reset count", ptc_pkg::OFF_CNT_LO, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_clk();
    t_cmp();
    t_clr();
    t_pwm();
    t_ovf();
    give_verdict();
  end
endmodule

// file: ptc_core.sv
// Purpose: 16-bit periodic timer with two comparators behind apb
// Assumes: pclk is the system clock; high and sub clocks arrive as one-cycle ticks, the external clock as a pin level
// Notes: register file, counter, comparators and output pin in one module
// Function
// RULE1 - 16-bit up-counter steps on selected clock edge
// RULE2 - comparators A and P match all 16 bits
// RULE3 - on rise clears count, fall holds it
// RULE4 - overflow or selected match clears, raising flags
// RULE5 - hold bit freezes count, release resumes
// RULE6 - three-bit field selects counter clock source
// RULE7 - counter off means no counting
// RULE8 - on rise restores initial output level
// RULE9 - control zero bits 2..0 read zero
// RULE10 - two-bit field selects operating mode
// RULE11 - software switches off before changing mode
// RULE12 - compare mode A match drives pin per field
// RULE13 - pwm mode pin field forces output function
// RULE14 - match level equal to initial shows no change
// RULE15 - software changes pwm pin field only off
// RULE16 - level bit sets initial or active level
// RULE17 - invert bit flips pin except timer mode
// RULE18 - software writes zero to reserved bit
// RULE19 - clear source picks A or P/overflow
// RULE20 - count readable, compare and period writable
// RULE21 - inverse pin always complements main pin
// RULE22 - clear on A suppresses comparator P flag
// RULE23 - zero compare A overflows without A flag
// RULE24 - count wraps from maximum to zero
`timescale 1ns/1ps
module ptc_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ptc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic high_clock_tick,
  input wire logic sub_clock_tick,
  input wire logic external_count_clock_pin,
  output logic timer_output_pin,
  output logic timer_output_pin_inverse,
  output logic compare_a_flag,
  output logic compare_p_flag
);
  logic [7:0] ctl0_reg;
  logic [7:0] ctl1_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] cmp_a_reg;
  logic [15:0] period_reg;
  logic [1:0] flags_reg;
  logic [1:0] flags_next;
  logic [1:0] sys_div_reg;
  logic [5:0] hs_div_reg;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_s3_reg;
  logic out_lvl_reg;
  logic out_lvl_next;
  logic pin_reg;
  logic pin_inv_reg;
  logic pin_next;

  function automatic logic val_hit(input logic [15:0] cnt, input logic [15:0] val);
    val_hit = (cnt == val);
  endfunction

  // apb decode
  wire wr_en = psel & penable & pwrite;
  wire sel_ctl0 = (paddr == ptc_pkg::OFF_CTL0);
  wire sel_ctl1 = (paddr == ptc_pkg::OFF_CTL1);
  wire sel_cnt_lo = (paddr == ptc_pkg::OFF_CNT_LO);
  wire sel_cnt_hi = (paddr == ptc_pkg::OFF_CNT_HI);
  wire sel_a_lo = (paddr == ptc_pkg::OFF_CMPA_LO);
  wire sel_a_hi = (paddr == ptc_pkg::OFF_CMPA_HI);
  wire sel_p_lo = (paddr == ptc_pkg::OFF_PER_LO);
  wire sel_p_hi = (paddr == ptc_pkg::OFF_PER_HI);
  wire sel_flags = (paddr == ptc_pkg::OFF_FLAGS);
  wire mapped = sel_ctl0 | sel_ctl1 | sel_cnt_lo | sel_cnt_hi | sel_a_lo | sel_a_hi | sel_p_lo | sel_p_hi | sel_flags;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    prdata = 32'h0000_0000;
    if (sel_ctl0) begin
      prdata[7:3] = ctl0_reg[7:3]; // [RULE9]
    end else if (sel_ctl1) begin
      prdata[7:0] = ctl1_reg;
    end else if (sel_cnt_lo) begin
      prdata[7:0] = count_reg[7:0]; // [RULE20]
    end else if (sel_cnt_hi) begin
      prdata[7:0] = count_reg[15:8]; // [RULE20]
    end else if (sel_a_lo) begin
      prdata[7:0] = cmp_a_reg[7:0];
    end else if (sel_a_hi) begin
      prdata[7:0] = cmp_a_reg[15:8];
    end else if (sel_p_lo) begin
      prdata[7:0] = period_reg[7:0];
    end else if (sel_p_hi) begin
      prdata[7:0] = period_reg[15:8];
    end else if (sel_flags) begin
      prdata[1:0] = flags_reg;
    end
  end

  // control fields
  wire on_bit = ctl0_reg[ptc_pkg::C0_ON];
  wire hold_bit = ctl0_reg[ptc_pkg::C0_HOLD];
  wire [2:0] ck_sel = ctl0_reg[ptc_pkg::C0_CKSEL_LSB +: 3];
  wire [1:0] mode = ctl1_reg[ptc_pkg::C1_MODE_LSB +: 2]; // [RULE10]
  wire [1:0] pin_fn = ctl1_reg[ptc_pkg::C1_PINF_LSB +: 2];
  wire olvl = ctl1_reg[ptc_pkg::C1_OLVL];
  wire inv = ctl1_reg[ptc_pkg::C1_INV];
  wire cclr = ctl1_reg[ptc_pkg::C1_CCLR];
  wire m_cmp = (mode == ptc_pkg::MODE_CMP);
  wire m_pwm = (mode == ptc_pkg::MODE_PWM);
  wire m_sp = m_pwm & (pin_fn == ptc_pkg::PF_TOGGLE);
  // the undefined mode code is run like timer mode with the pin parked low
  wire m_tc = ~m_cmp & ~m_pwm;

  // software on bit edge; a write is the only way it can rise
  wire wr_ctl0 = wr_en & sel_ctl0;
  wire on_set_ev = wr_ctl0 & pwdata[ptc_pkg::C0_ON] & ~on_bit; // [RULE3]

  // clock source ticks
  wire tick_sys4 = (sys_div_reg == ptc_pkg::SYS_DIV_LAST);
  wire tick_h16 = high_clock_tick & (hs_div_reg[3:0] == ptc_pkg::HS16_LAST);
  wire tick_h64 = high_clock_tick & (hs_div_reg == ptc_pkg::HS64_LAST);
  // edge detect reads only the second and third stages, never the first
  wire ext_rise = ext_s2_reg & ~ext_s3_reg;
  wire ext_fall = ~ext_s2_reg & ext_s3_reg;
  logic tick;
  always_comb begin
    case (ck_sel) // [RULE6]
      ptc_pkg::CK_SYS4: tick = tick_sys4;
      ptc_pkg::CK_SYS: tick = 1'b1;
      ptc_pkg::CK_H16: tick = tick_h16;
      ptc_pkg::CK_H64: tick = tick_h64;
      ptc_pkg::CK_SUB0: tick = sub_clock_tick;
      ptc_pkg::CK_SUB1: tick = sub_clock_tick;
      ptc_pkg::CK_EXT_R: tick = ext_rise;
      default: tick = ext_fall;
    endcase
  end

  // comparators and counting events
  wire run = on_bit & ~hold_bit; // [RULE5] [RULE7]
  wire tick_run = run & tick;
  wire a_eq = val_hit(count_reg, cmp_a_reg); // [RULE2]
  wire p_eq = (period_reg == ptc_pkg::VAL_RST) ? val_hit(count_reg, ptc_pkg::CNT_MAX)
                                                : val_hit(count_reg, period_reg); // [RULE2]
  wire a_ev = tick_run & a_eq & (cmp_a_reg != ptc_pkg::VAL_RST); // [RULE23]
  wire p_ev = tick_run & p_eq;
  // single pulse never clears the count; pwm ignores the clear source
  wire clear_ev = m_sp ? 1'b0 : (m_pwm ? p_ev : (cclr ? a_ev : p_ev)); // [RULE4] [RULE19]
  wire a_set = a_ev;
  wire p_set = p_ev & ~m_sp & ~(cclr & ~m_pwm); // [RULE22]
  wire sp_end = m_sp & a_ev;

  always_comb begin
    count_next = count_reg;
    if (on_set_ev) begin
      count_next = ptc_pkg::VAL_RST; // [RULE3]
    end else if (tick_run && clear_ev) begin
      count_next = ptc_pkg::VAL_RST; // [RULE4]
    end else if (tick_run) begin
      count_next = 16'(count_reg + 16'h0001); // [RULE1] [RULE24]
    end
  end

  // hardware set wins over a write-one clear in the same cycle
  wire [1:0] flag_clr = (wr_en & sel_flags) ? pwdata[1:0] : 2'h0;
  assign flags_next = (flags_reg & ~flag_clr) | {p_set, a_set}; // [RULE4]

  // output level before polarity
  always_comb begin
    out_lvl_next = out_lvl_reg;
    if (on_set_ev && !m_tc) begin
      out_lvl_next = olvl; // [RULE8] [RULE16]
    end else if (m_cmp && a_set) begin
      case (pin_fn) // [RULE12] [RULE14]
        ptc_pkg::PF_LOW: out_lvl_next = 1'b0;
        ptc_pkg::PF_HIGH: out_lvl_next = 1'b1;
        ptc_pkg::PF_TOGGLE: out_lvl_next = ~out_lvl_reg;
        default: out_lvl_next = out_lvl_reg;
      endcase
    end
  end

  logic drive_lvl;
  always_comb begin
    drive_lvl = out_lvl_reg;
    if (m_pwm) begin
      case (pin_fn) // [RULE13] [RULE16]
        ptc_pkg::PF_NONE: drive_lvl = ~olvl;
        ptc_pkg::PF_LOW: drive_lvl = olvl;
        ptc_pkg::PF_HIGH: drive_lvl = (count_reg < cmp_a_reg) ? olvl : ~olvl;
        default: drive_lvl = on_bit ? olvl : ~olvl;
      endcase
    end
  end
  assign pin_next = m_tc ? 1'b0 : (drive_lvl ^ inv); // [RULE17]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl0_reg <= ptc_pkg::CTL0_RST;
      ctl1_reg <= ptc_pkg::CTL1_RST;
      cmp_a_reg <= ptc_pkg::VAL_RST;
      period_reg <= ptc_pkg::VAL_RST;
    end else begin
      if (wr_ctl0) begin
        ctl0_reg <= {pwdata[7:3], 3'h0};
      end else if (sp_end) begin
        ctl0_reg[ptc_pkg::C0_ON] <= 1'b0;
      end
      if (wr_en && sel_ctl1) begin
        ctl1_reg <= pwdata[7:0];
      end
      if (wr_en && sel_a_lo) begin
        cmp_a_reg[7:0] <= pwdata[7:0]; // [RULE20]
      end
      if (wr_en && sel_a_hi) begin
        cmp_a_reg[15:8] <= pwdata[7:0];
      end
      if (wr_en && sel_p_lo) begin
        period_reg[7:0] <= pwdata[7:0];
      end
      if (wr_en && sel_p_hi) begin
        period_reg[15:8] <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= ptc_pkg::VAL_RST;
      flags_reg <= 2'h0;
      out_lvl_reg <= 1'b0;
      pin_reg <= 1'b0;
      pin_inv_reg <= 1'b1;
    end else begin
      count_reg <= count_next;
      flags_reg <= flags_next;
      out_lvl_reg <= out_lvl_next;
      pin_reg <= pin_next;
      pin_inv_reg <= ~pin_next; // [RULE21]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_div_reg <= 2'h0;
      hs_div_reg <= 6'h00;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      sys_div_reg <= 2'(sys_div_reg + 2'h1);
      if (high_clock_tick) begin
        hs_div_reg <= 6'(hs_div_reg + 6'h01);
      end
      ext_s1_reg <= external_count_clock_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  assign timer_output_pin = pin_reg;
  assign timer_output_pin_inverse = pin_inv_reg;
  assign compare_a_flag = flags_reg[ptc_pkg::FL_A];
  assign compare_p_flag = flags_reg[ptc_pkg::FL_P];

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_on_rise_clear;
    on_set_ev |=> (count_reg == 16'h0000) && on_bit;
  endproperty
  a_on_rise_clear: assert property (p_on_rise_clear) else $error("count not cleared on enable"); // [RULE3]

  property p_hold_freeze;
    (hold_bit && !on_set_ev) |=> (count_reg == $past(count_reg));
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("count moved while held"); // [RULE5]

  property p_off_still;
    (!on_bit && !on_set_ev) ##1 (!on_bit && !on_set_ev) |-> (count_reg == $past(count_reg));
  endproperty
  a_off_still: assert property (p_off_still) else $error("count moved while off"); // [RULE7]

  property p_count_step;
    (tick_run && !clear_ev && !on_set_ev) |=> (count_reg == 16'($past(count_reg) + 16'h0001));
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step by one"); // [RULE1]

  property p_wrap;
    (tick_run && count_reg == 16'hffff && !on_set_ev) |=> (count_reg == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap to zero"); // [RULE24]

  property p_inverse;
    timer_output_pin_inverse == !timer_output_pin;
  endproperty
  a_inverse: assert property (p_inverse) else $error("inverse pin not complement"); // [RULE21]

  property p_no_p_flag;
    (m_cmp && cclr && !compare_p_flag && !(wr_en && sel_ctl1)) |=> !compare_p_flag;
  endproperty
  a_no_p_flag: assert property (p_no_p_flag) else $error("comparator P flag set while clearing on A"); // [RULE22]

  property p_zero_a;
    (cmp_a_reg == 16'h0000 && !compare_a_flag && !(wr_en && (sel_a_lo || sel_a_hi))) |=> !compare_a_flag;
  endproperty
  a_zero_a: assert property (p_zero_a) else $error("A flag with zero compare value"); // [RULE23]

  property p_ctl0_low_zero;
    (psel && !pwrite && sel_ctl0) |-> (prdata[2:0] == 3'h0);
  endproperty
  a_ctl0_low_zero: assert property (p_ctl0_low_zero) else $error("control zero low bits not zero"); // [RULE9]

  property p_toggle;
    (m_cmp && a_set && pin_fn == 2'h3 && !on_set_ev) |=> (out_lvl_reg != $past(out_lvl_reg)) ##1 (timer_output_pin == (out_lvl_reg ^ inv));
  endproperty
  a_toggle: assert property (p_toggle) else $error("compare A toggle missed"); // [RULE12]

  property p_sp_stop;
    (sp_end && !wr_ctl0) |=> !on_bit;
  endproperty
  a_sp_stop: assert property (p_sp_stop) else $error("single pulse did not switch off"); // [RULE13]

  property p_clear_p;
    (m_cmp && !cclr && tick_run && p_eq && !on_set_ev) |=> (count_reg == 16'h0000);
  endproperty
  a_clear_p: assert property (p_clear_p) else $error("count not cleared on P match"); // [RULE19]

  c_a_match: cover property (m_cmp && a_set);
  c_wrap: cover property (tick_run && count_reg == 16'hffff);
  c_pwm_run: cover property (m_pwm && pin_fn == 2'h2 && tick_run);
  c_sp_end: cover property (sp_end);
endmodule

// file: ptc_ext_model.sv
// Purpose: far-side model that drives the external count clock pin
// Assumes: pin idles low outside bursts
// Notes: toggles every 4 pclk cycles while run is high; even toggle counts end low
`timescale 1ns/1ps
module ptc_ext_model (
  input wire logic pclk,
  input wire logic run,
  output logic external_count_clock_pin
);
  logic [1:0] div_reg = 2'h0;
  logic pin_reg = 1'b0;
  assign external_count_clock_pin = pin_reg;
  always @(posedge pclk) begin
    if (!run) begin
      div_reg <= 2'h0;
      pin_reg <= 1'b0;
    end else begin
      div_reg <= 2'(div_reg + 2'h1);
      if (div_reg == 2'h3) pin_reg <= !pin_reg;
    end
  end
endmodule

// file: ptc_pkg.sv
// Purpose: shared constants of the periodic timer core
// Assumes: apb byte addresses, one register per 32-bit word
// Notes: register offsets are local choices
package ptc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTL0 = 8'h00;
  localparam logic [7:0] OFF_CTL1 = 8'h04;
  localparam logic [7:0] OFF_CNT_LO = 8'h08;
  localparam logic [7:0] OFF_CNT_HI = 8'h0c;
  localparam logic [7:0] OFF_CMPA_LO = 8'h10;
  localparam logic [7:0] OFF_CMPA_HI = 8'h14;
  localparam logic [7:0] OFF_PER_LO = 8'h18;
  localparam logic [7:0] OFF_PER_HI = 8'h1c;
  localparam logic [7:0] OFF_FLAGS = 8'h20;
  // control zero fields
  localparam int C0_HOLD = 7;
  localparam int C0_CKSEL_LSB = 4;
  localparam int C0_ON = 3;
  // control one fields
  localparam int C1_MODE_LSB = 6;
  localparam int C1_PINF_LSB = 4;
  localparam int C1_OLVL = 3;
  localparam int C1_INV = 2;
  localparam int C1_CCLR = 0;
  // flag register fields
  localparam int FL_A = 0;
  localparam int FL_P = 1;
  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [1:0] SYS_DIV_LAST = 2'h3;
  localparam logic [3:0] HS16_LAST = 4'hf;
  localparam logic [5:0] HS64_LAST = 6'h3f;
  typedef enum logic [1:0] {MODE_CMP = 2'h0, MODE_UNDEF = 2'h1, MODE_PWM = 2'h2, MODE_TC = 2'h3} ptc_mode_t;
  typedef enum logic [2:0] {
    CK_SYS4 = 3'h0, CK_SYS = 3'h1, CK_H16 = 3'h2, CK_H64 = 3'h3,
    CK_SUB0 = 3'h4, CK_SUB1 = 3'h5, CK_EXT_R = 3'h6, CK_EXT_F = 3'h7
  } ptc_cksel_t;
  localparam logic [1:0] PF_NONE = 2'h0;
  localparam logic [1:0] PF_LOW = 2'h1;
  localparam logic [1:0] PF_HIGH = 2'h2;
  localparam logic [1:0] PF_TOGGLE = 2'h3;
endpackage
